// file: rtl/dma_socket_descriptor_regs.sv
`timescale 1ns/10ps
module dma_socket_descriptor_regs
    import sock_dscr_pkg::*;
#(
    parameter logic [5:0] OWN_BLOCK  = 6'h01,
    parameter logic [7:0] OWN_SOCKET = 8'h00
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Descriptor fetch from memory
    input  wire logic        fetch_valid,
    input  wire logic [15:0] fetch_number,
    input  wire logic [31:0] fetch_buffer,
    input  wire sync_s       fetch_sync,
    input  wire chain_s      fetch_chain,
    input  wire size_s       fetch_size,
    // Streaming core side
    input  wire logic        core_done,
    input  wire logic [15:0] core_byte_count,
    input  wire logic        core_eop,
    input  wire logic        core_error,
    output logic             core_eop_return,
    output logic             core_marker,
    // Writeback and outgoing events
    output logic             wb_valid,
    output logic      [15:0] wb_number,
    output size_s            wb_size,
    output evt_s             evt_out,
    // Interrupt request and state
    input  wire logic [9:0]  hw_intr_set,
    output logic      [9:0]  socket_interrupt_request,
    output logic             cpu_intr,
    output logic      [15:0] dscr_number,
    output logic      [19:0] buf_capacity
);

    logic [31:0] buffer_r;
    sync_s       sync_r;
    chain_s      chain_r;
    size_s       size_r;
    logic [9:0]  mask_r;
    logic [9:0]  intr_r;
    logic [9:0]  intr_nxt;
    logic [15:0] dscr_r;
    logic        socket_produce_events_on;
    logic        socket_consume_events_on;
    logic        socket_idle;
    logic        ev_wr;
    logic        ev_produce;
    logic        ev_hits;
    logic        send_prod;
    logic        send_cons;
    logic        prod_to_cpu;
    logic        cons_to_cpu;
    logic [31:0] rdata_nxt;

    function automatic logic is_self(input logic [5:0] blk, input logic [7:0] sck);
        is_self = (blk == OWN_BLOCK) && (sck == OWN_SOCKET);
    endfunction : is_self

    // Size word as it stands once the core has finished the buffer
    function automatic size_s completed(input size_s cur, input logic [15:0] cnt, input logic eop,
                                        input logic err);
        completed            = cur;
        completed.byte_count = cnt;
        completed.eop        = eop;
        completed.buf_error  = err;
        completed.occupied   = ~cur.occupied;
    endfunction : completed

    // Descriptor words
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            buffer_r <= RESET_WORD;
            sync_r   <= '0;
            dscr_r   <= RESET_DSCR;
        end else if (fetch_valid) begin
            buffer_r <= fetch_buffer;
            sync_r   <= fetch_sync;
            dscr_r   <= fetch_number;
        end
    end

    // Chain may be patched by software while idle; the adapter owns it otherwise
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chain_r <= '0;
        end else if (fetch_valid) begin
            chain_r <= fetch_chain;
        end else if (reg_wr && reg_addr == OFS_CHAIN && socket_idle) begin
            chain_r <= reg_wdata;
        end
    end

    // Event targets and gating
    assign ev_wr      = reg_wr && reg_addr == OFS_EVENT;
    assign ev_produce = reg_wdata[EVT_TYPE_BIT];
    assign ev_hits    = ev_wr && reg_wdata[15:0] == dscr_r;
    // Role follows the flag: an empty buffer was filled, a full one drained
    assign send_prod  = core_done && !size_r.occupied && sync_r.en_prod_evt && socket_produce_events_on;
    assign send_cons  = core_done && size_r.occupied && sync_r.en_cons_evt && socket_consume_events_on;
    assign prod_to_cpu = send_prod && sync_r.consumer_block_number == CPU_BLOCK;
    assign cons_to_cpu = send_cons && sync_r.producer_block_number == CPU_BLOCK;

    // Size word: after fetch only eop, count, error, occupied move
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            size_r <= '0;
        end else if (fetch_valid) begin
            size_r <= fetch_size;
        end else if (core_done) begin
            // Count, end marker and error come from the core; occupied flips
            size_r <= completed(size_r, core_byte_count, core_eop, core_error);
        end else if (ev_hits) begin
            size_r.occupied <= ev_produce;
        end
    end

    // Writeback and event out, one cycle after completion
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_valid  <= 1'b0;
            wb_number <= RESET_DSCR;
            wb_size   <= '0;
            evt_out   <= '0;
        end else begin
            wb_valid  <= send_prod || send_cons;
            wb_number <= dscr_r;
            // Memory must get the finished word, not the one fetched
            wb_size   <= completed(size_r, core_byte_count, core_eop, core_error);
            evt_out.valid      <= (send_prod && !prod_to_cpu) || (send_cons && !cons_to_cpu);
            evt_out.is_produce <= send_prod;
            evt_out.block      <= send_prod ? sync_r.consumer_block_number : sync_r.producer_block_number;
            evt_out.sck        <= send_prod ? sync_r.cons_sck : sync_r.prod_sck;
        end
    end

    // Interrupt requests: set wins over a clear in the same cycle
    always_comb begin
        intr_nxt = intr_r;
        if (reg_wr && reg_addr == OFS_INTR) begin
            intr_nxt = intr_nxt & ~reg_wdata[INTR_BITS-1:0];
        end
        intr_nxt = intr_nxt | hw_intr_set;
        if (send_prod && (sync_r.en_prod_int || prod_to_cpu)) intr_nxt[I_PROD] = 1'b1;
        if (send_cons && (sync_r.en_cons_int || cons_to_cpu)) intr_nxt[I_CONS] = 1'b1;
        // Own-socket events count as received
        if (evt_out.valid && is_self(evt_out.block, evt_out.sck)) begin
            intr_nxt[evt_out.is_produce ? I_PROD : I_CONS] = 1'b1;
        end
        if (dscr_r == END_OF_LIST) intr_nxt[I_NOT_AVL] = 1'b1;
        if (core_done && core_error) intr_nxt[I_ERROR] = 1'b1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            intr_r <= RESET_MASK;
        end else begin
            intr_r <= intr_nxt;
        end
    end

    // Mask and control
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mask_r                   <= RESET_MASK;
            socket_produce_events_on <= 1'b0;
            socket_consume_events_on <= 1'b0;
            socket_idle              <= 1'b1;
        end else if (reg_wr && reg_addr == OFS_MASK) begin
            mask_r <= reg_wdata[INTR_BITS-1:0];
        end else if (reg_wr && reg_addr == OFS_CTRL) begin
            socket_produce_events_on <= reg_wdata[CTRL_PROD_BIT];
            socket_consume_events_on <= reg_wdata[CTRL_CONS_BIT];
            socket_idle              <= reg_wdata[CTRL_IDLE_BIT];
        end
    end

    assign socket_interrupt_request = intr_r;
    assign cpu_intr        = |(intr_r & mask_r);
    assign core_eop_return = size_r.eop;
    assign core_marker     = size_r.marker;
    assign dscr_number     = dscr_r;
    assign buf_capacity    = {8'h00, size_r.buf_size} << SIZE_UNIT_LOG;

    // Read mux; event location and holes read zero
    always_comb begin
        case (reg_addr)
            OFS_INTR:   rdata_nxt = {22'h000000, intr_r};
            OFS_MASK:   rdata_nxt = {22'h000000, mask_r};
            OFS_BUFFER: rdata_nxt = buffer_r;
            OFS_SYNC:   rdata_nxt = sync_r;
            OFS_CHAIN:  rdata_nxt = chain_r;
            OFS_SIZE:   rdata_nxt = size_r;
            OFS_CTRL:   rdata_nxt = {29'h00000000, socket_idle, socket_consume_events_on,
                                     socket_produce_events_on};
            default:    rdata_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= RESET_WORD;
        end else begin
            reg_rdata <= reg_rd ? rdata_nxt : RESET_WORD;
        end
    end

    property p_mask_report;
        @(posedge clk) disable iff (rst) (|(intr_r & mask_r)) |-> cpu_intr;
    endproperty
    a_mask_report: assert property (p_mask_report) else $error("masked request not reported");

    property p_no_avl;
        @(posedge clk) disable iff (rst) (dscr_r == END_OF_LIST) |=> intr_r[I_NOT_AVL];
    endproperty
    a_no_avl: assert property (p_no_avl) else $error("not-available not raised");

    property p_prod_gate;
        @(posedge clk) disable iff (rst) (core_done && !sync_r.en_prod_evt && !send_cons) |=> !wb_valid;
    endproperty
    a_prod_gate: assert property (p_prod_gate) else $error("writeback without enable");

    property p_cons_gate;
        @(posedge clk) disable iff (rst) (core_done && !socket_consume_events_on && !send_prod) |=> !wb_valid;
    endproperty
    a_cons_gate: assert property (p_cons_gate) else $error("consume writeback without enable");

    property p_event_occ;
        @(posedge clk) disable iff (rst)
            (ev_hits && !fetch_valid && !core_done) |=> size_r.occupied == $past(ev_produce);
    endproperty
    a_event_occ: assert property (p_event_occ) else $error("event did not move occupied");

    property p_fetch_load;
        @(posedge clk) disable iff (rst) fetch_valid |=> buffer_r == $past(fetch_buffer);
    endproperty
    a_fetch_load: assert property (p_fetch_load) else $error("buffer base not loaded");

    property p_chain_busy;
        @(posedge clk) disable iff (rst) (!socket_idle && !fetch_valid) |=> $stable(chain_r);
    endproperty
    a_chain_busy: assert property (p_chain_busy) else $error("chain changed while active");

    property p_size_fixed;
        @(posedge clk) disable iff (rst) !fetch_valid |=> $stable(size_r.buf_size) && $stable(size_r.marker);
    endproperty
    a_size_fixed: assert property (p_size_fixed) else $error("fixed size field changed");

    property p_mask_keeps_req;
        @(posedge clk) disable iff (rst) (reg_wr && reg_addr == OFS_MASK) |=> ($past(intr_r) & ~intr_r) == 10'h000;
    endproperty
    a_mask_keeps_req: assert property (p_mask_keeps_req) else $error("mask write cleared a request");

    property p_mask_load;
        @(posedge clk) disable iff (rst)
            (reg_wr && reg_addr == OFS_MASK) |=> {22'h000000, mask_r} == ($past(reg_wdata) & 32'h0000_03FF);
    endproperty
    a_mask_load: assert property (p_mask_load) else $error("mask not loaded");

    property p_buf_hold;
        @(posedge clk) disable iff (rst) !fetch_valid |=> $stable(buffer_r);
    endproperty
    a_buf_hold: assert property (p_buf_hold) else $error("buffer base changed without fetch");

    property p_sync_hold;
        @(posedge clk) disable iff (rst) !fetch_valid |=> $stable(sync_r);
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("sync word changed without fetch");

    property p_sync_load;
        @(posedge clk) disable iff (rst) fetch_valid |=> sync_r == $past(fetch_sync);
    endproperty
    a_sync_load: assert property (p_sync_load) else $error("sync word not loaded");

    property p_prod_cpu_drop;
        @(posedge clk) disable iff (rst) (send_prod && sync_r.consumer_block_number == CPU_BLOCK) |=> !evt_out.valid;
    endproperty
    a_prod_cpu_drop: assert property (p_prod_cpu_drop) else $error("produce event to CPU not dropped");

    property p_cons_cpu_drop;
        @(posedge clk) disable iff (rst) (send_cons && sync_r.producer_block_number == CPU_BLOCK) |=> !evt_out.valid;
    endproperty
    a_cons_cpu_drop: assert property (p_cons_cpu_drop) else $error("consume event to CPU not dropped");

    property p_prod_cpu_intr;
        @(posedge clk) disable iff (rst) (send_prod && sync_r.consumer_block_number == CPU_BLOCK) |=> intr_r[I_PROD];
    endproperty
    a_prod_cpu_intr: assert property (p_prod_cpu_intr) else $error("CPU produce event not logged");

    property p_cons_cpu_intr;
        @(posedge clk) disable iff (rst) (send_cons && sync_r.producer_block_number == CPU_BLOCK) |=> intr_r[I_CONS];
    endproperty
    a_cons_cpu_intr: assert property (p_cons_cpu_intr) else $error("CPU consume event not logged");

    property p_prod_target;
        @(posedge clk) disable iff (rst) send_prod |=> evt_out.is_produce && evt_out.sck == $past(sync_r.cons_sck);
    endproperty
    a_prod_target: assert property (p_prod_target) else $error("produce event to wrong socket");

    property p_cons_target;
        @(posedge clk) disable iff (rst) send_cons |=> !evt_out.is_produce && evt_out.sck == $past(sync_r.prod_sck);
    endproperty
    a_cons_target: assert property (p_cons_target) else $error("consume event to wrong socket");

    property p_prod_log;
        @(posedge clk) disable iff (rst) (send_prod && sync_r.en_prod_int) |=> intr_r[I_PROD];
    endproperty
    a_prod_log: assert property (p_prod_log) else $error("produce interrupt not logged");

    property p_cons_log;
        @(posedge clk) disable iff (rst) (send_cons && sync_r.en_cons_int) |=> intr_r[I_CONS];
    endproperty
    a_cons_log: assert property (p_cons_log) else $error("consume interrupt not logged");

    property p_no_mask_quiet;
        @(posedge clk) disable iff (rst) (mask_r == 10'h000) |-> !cpu_intr;
    endproperty
    a_no_mask_quiet: assert property (p_no_mask_quiet) else $error("unmasked request reached CPU");

    property p_count_load;
        @(posedge clk) disable iff (rst)
            (core_done && !fetch_valid) |=> size_r.byte_count == $past(core_byte_count);
    endproperty
    a_count_load: assert property (p_count_load) else $error("byte count not recorded");

    property p_eop_load;
        @(posedge clk) disable iff (rst) (core_done && !fetch_valid) |=> core_eop_return == $past(core_eop);
    endproperty
    a_eop_load: assert property (p_eop_load) else $error("end marker not returned");

    property p_err_load;
        @(posedge clk) disable iff (rst) (core_done && !fetch_valid) |=> size_r.buf_error == $past(core_error);
    endproperty
    a_err_load: assert property (p_err_load) else $error("error flag not recorded");

    property p_occ_flip;
        @(posedge clk) disable iff (rst)
            (core_done && !fetch_valid) |=> size_r.occupied != $past(size_r.occupied);
    endproperty
    a_occ_flip: assert property (p_occ_flip) else $error("occupied flag did not flip");

    property p_capacity;
        @(posedge clk) disable iff (rst) 1'b1 |-> buf_capacity == {4'h0, size_r.buf_size, 4'h0};
    endproperty
    a_capacity: assert property (p_capacity) else $error("capacity not sixteen bytes a unit");

    property p_wb_word;
        @(posedge clk) disable iff (rst) ((send_prod || send_cons) && !fetch_valid) |=> wb_size == size_r;
    endproperty
    a_wb_word: assert property (p_wb_word) else $error("writeback differs from size word");

    property p_wb_number;
        @(posedge clk) disable iff (rst) ((send_prod || send_cons) && !fetch_valid) |=> wb_number == $past(dscr_r);
    endproperty
    a_wb_number: assert property (p_wb_number) else $error("writeback to wrong descriptor");

    property p_size_read;
        @(posedge clk) disable iff (rst) (reg_rd && reg_addr == OFS_SIZE) |=> reg_rdata == $past(size_r);
    endproperty
    a_size_read: assert property (p_size_read) else $error("size word read wrong");

    property p_event_read;
        @(posedge clk) disable iff (rst) (reg_rd && reg_addr == OFS_EVENT) |=> reg_rdata == 32'h0000_0000;
    endproperty
    a_event_read: assert property (p_event_read) else $error("event location read not zero");

    property p_chain_patch;
        @(posedge clk) disable iff (rst)
            (reg_wr && reg_addr == OFS_CHAIN && socket_idle && !fetch_valid) |=> chain_r == $past(reg_wdata);
    endproperty
    a_chain_patch: assert property (p_chain_patch) else $error("idle chain write lost");

    property p_event_miss;
        @(posedge clk) disable iff (rst) (ev_wr && !ev_hits && !fetch_valid && !core_done) |=> $stable(size_r);
    endproperty
    a_event_miss: assert property (p_event_miss) else $error("event for other descriptor moved size");

endmodule : dma_socket_descriptor_regs

// file: rtl/sock_dscr_pkg.sv
package sock_dscr_pkg;
    localparam logic [7:0]  OFS_INTR      = 8'h10;
    localparam logic [7:0]  OFS_MASK      = 8'h14;
    localparam logic [7:0]  OFS_BUFFER    = 8'h20;
    localparam logic [7:0]  OFS_SYNC      = 8'h24;
    localparam logic [7:0]  OFS_CHAIN     = 8'h28;
    localparam logic [7:0]  OFS_SIZE      = 8'h2C;
    localparam logic [7:0]  OFS_CTRL      = 8'h30;
    localparam logic [7:0]  OFS_EVENT     = 8'h7C;
    localparam int          INTR_BITS     = 10;
    localparam int          EVT_TYPE_BIT  = 16;
    localparam int          CTRL_PROD_BIT = 0;
    localparam int          CTRL_CONS_BIT = 1;
    localparam int          CTRL_IDLE_BIT = 2;
    localparam logic [5:0]  CPU_BLOCK     = 6'h3F;
    localparam logic [15:0] END_OF_LIST   = 16'hFFFF;
    localparam logic [31:0] RESET_WORD    = 32'h0000_0000;
    localparam logic [9:0]  RESET_MASK    = 10'h000;
    localparam logic [15:0] RESET_DSCR    = 16'hFFFF;
    localparam int          SIZE_UNIT_LOG = 4;
    localparam int          I_PROD        = 0;
    localparam int          I_CONS        = 1;
    localparam int          I_NOT_AVL     = 3;
    localparam int          I_ERROR       = 6;

    typedef struct packed {
        logic        en_prod_int;
        logic        en_prod_evt;
        logic [5:0]  producer_block_number;
        logic [7:0]  prod_sck;
        logic        en_cons_int;
        logic        en_cons_evt;
        logic [5:0]  consumer_block_number;
        logic [7:0]  cons_sck;
    } sync_s;

    typedef struct packed {
        logic [15:0] byte_count;
        logic [11:0] buf_size;
        logic        occupied;
        logic        buf_error;
        logic        eop;
        logic        marker;
    } size_s;

    typedef struct packed {
        logic [15:0] wr_next;
        logic [15:0] rd_next;
    } chain_s;

    typedef struct packed {
        logic        valid;
        logic        is_produce;
        logic [5:0]  block;
        logic [7:0]  sck;
    } evt_s;
endpackage : sock_dscr_pkg

// file: testbench/core_mem_model.sv
`timescale 1ns/10ps
module core_mem_model
    import sock_dscr_pkg::*;
(
    // Clock
    input  wire logic        clk,
    // Descriptor fetch
    output logic             fetch_valid,
    output logic      [15:0] fetch_number,
    output logic      [31:0] fetch_buffer,
    output sync_s            fetch_sync,
    output chain_s           fetch_chain,
    output size_s            fetch_size,
    // Core markers
    output logic             core_done,
    output logic      [15:0] core_byte_count,
    output logic             core_eop,
    output logic             core_error,
    // Writeback
    input  wire logic        wb_valid,
    input  wire logic [15:0] wb_number,
    input  wire size_s       wb_size
);
    logic [143:0] fw;
    logic [17:0]  cw;
    logic [31:0]  mem [logic [15:0]];

    assign {fetch_number, fetch_buffer, fetch_sync, fetch_chain, fetch_size} = fw;
    assign {core_byte_count, core_eop, core_error} = cw;

    initial begin
        {fetch_valid, core_done, fw, cw} = '0;
    end

    // Only the size word ever comes back
    always @(posedge clk) begin
        if (wb_valid === 1'b1)
            mem[wb_number] = wb_size;
    end

    task automatic fetch(input logic [143:0] w);
        @(posedge clk);
        {fetch_valid, fw} <= {1'b1, w};
        @(posedge clk);
        // Released words inverted so stale data never passes
        {fetch_valid, fw} <= {1'b0, ~w};
    endtask : fetch

    task automatic done(input logic [17:0] w);
        @(posedge clk);
        {core_done, cw} <= {1'b1, w};
        @(posedge clk);
        {core_done, cw} <= {1'b0, ~w};
    endtask : done
endmodule : core_mem_model

// file: testbench/dma_socket_descriptor_regs_tb_top.sv
`timescale 1ns/10ps
module dma_socket_descriptor_regs_tb_top
    import sock_dscr_pkg::*;
;
    logic        clk, rst, reg_wr, reg_rd, fetch_valid, core_done, core_eop, core_error;
    logic        core_eop_return, core_marker, wb_valid, cpu_intr;
    logic [7:0]  reg_addr;
    logic [9:0]  hw_intr_set, socket_interrupt_request;
    logic [15:0] fetch_number, core_byte_count, wb_number, dscr_number;
    logic [19:0] buf_capacity;
    logic [31:0] reg_wdata, reg_rdata, fetch_buffer, m;
    sync_s       fetch_sync;
    chain_s      fetch_chain, c;
    size_s       fetch_size, wb_size;
    evt_s        evt_out;
    integer      seed = 80807, miscompares = 0, n_checks = 0, i;

    dma_socket_descriptor_regs u_dma_socket_descriptor_regs (.*);
    core_mem_model u_core_mem_model (.*);

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        #40000;
        miscompares = miscompares + 1;
        close_out();
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rc

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out

    // One fill or drain under one mix of enables
    task automatic one(input logic [4:0] k);
        logic        occ, den, sen, cpu, ien, snd, e, er;
        logic [15:0] n, cnt, ev;
        logic [31:0] b;
        sync_s       s;
        size_s       z, zw;
        {ien, cpu, sen, den, occ} = k;
        {s, z, b, c} = {$random(seed), $random(seed), $random(seed), $random(seed)};
        {n, cnt, e, er} = {1'b0, 15'($random(seed)), 16'($random(seed)), 2'($random(seed))};
        {s.en_prod_int, s.en_prod_evt, s.en_cons_int, s.en_cons_evt} = {ien, den, ien, den};
        // Blocks 0x10-0x1F: neither this socket nor the CPU
        s.producer_block_number = cpu ? CPU_BLOCK : {2'b01, s.producer_block_number[3:0]};
        s.consumer_block_number = cpu ? CPU_BLOCK : {2'b01, s.consumer_block_number[3:0]};
        {z.occupied, z.buf_error} = {occ, 1'b0};
        wr(OFS_CTRL, {29'h1, sen, sen});
        wr(OFS_INTR, 32'h3);
        u_core_mem_model.fetch({n, b, s, c, z});
        wr(OFS_BUFFER, ~b);
        wr(OFS_SYNC, ~s);
        wr(OFS_SIZE, ~z);
        rc(OFS_BUFFER, b);
        rc(OFS_SYNC, s);
        rc(OFS_CHAIN, c);
        rc(OFS_SIZE, z);
        chk(32'(dscr_number), 32'(n));
        chk(32'(buf_capacity), 32'(z.buf_size) * 16);
        chk(32'(core_marker), 32'(z.marker));
        u_core_mem_model.done({cnt, e, er});
        #1 snd = den & sen;
        zw = z;
        {zw.byte_count, zw.occupied, zw.buf_error, zw.eop} = {cnt, !occ, er, e};
        ev = {1'b1, !occ, occ ? {s.producer_block_number, s.prod_sck} : {s.consumer_block_number, s.cons_sck}};
        chk(32'(evt_out.valid ? evt_out : 16'h0), (snd & !cpu) ? 32'(ev) : 32'h0);
        if (!cpu)
            chk(32'(wb_valid), 32'(snd));
        if (snd & !cpu)
            chk(wb_size, zw);
        chk(32'(socket_interrupt_request & 10'h3),
            (snd & (cpu | ien)) ? 32'(1) << (occ ? I_CONS : I_PROD) : 32'h0);
        chk(32'(cpu_intr), 32'h0);
        chk(32'(core_eop_return), 32'(e));
        rc(OFS_SIZE, zw);
        if (snd & !cpu)
            chk(u_core_mem_model.mem[n], zw);
        wr(OFS_EVENT, {15'h0, occ, n});
        wr(OFS_EVENT, {15'h0, !occ, n ^ 16'h1});
        zw.occupied = occ;
        rc(OFS_SIZE, zw);
    endtask : one

    initial begin
        {rst, reg_wr, reg_rd, reg_addr, reg_wdata, hw_intr_set} = {1'b1, 52'h0};
        c = '0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rc(OFS_MASK, 32'h0);
        rc(OFS_INTR, 32'h8);
        rc(OFS_CTRL, 32'h4);
        rc(OFS_EVENT, 32'h0);
        rc(8'h40, 32'h0);
        chk(32'(dscr_number), 32'hFFFF);
        // Bit 4 on, bit 3 off, the rest random
        m = ($random(seed) & 32'h3E7) | 32'h10;
        wr(OFS_MASK, m);
        rc(OFS_MASK, m);
        @(posedge clk) hw_intr_set <= 10'h010;
        @(posedge clk) hw_intr_set <= 10'h000;
        #1 chk(32'(socket_interrupt_request), 32'h18);
        chk(32'(cpu_intr), 32'h1);
        wr(OFS_MASK, 32'h0);
        chk(32'(socket_interrupt_request), 32'h18);
        chk(32'(cpu_intr), 32'h0);
        wr(OFS_MASK, m);
        wr(OFS_INTR, 32'h10);
        rc(OFS_INTR, 32'h8);
        chk(32'(cpu_intr), 32'h0);
        wr(OFS_MASK, 32'h0);
        for (i = 0; i < 32; i++)
            one(i[4:0]);
        wr(OFS_CTRL, 32'h0);
        wr(OFS_CHAIN, ~c);
        rc(OFS_CHAIN, c);
        wr(OFS_CTRL, 32'h4);
        wr(OFS_CHAIN, {END_OF_LIST, END_OF_LIST});
        rc(OFS_CHAIN, 32'hFFFF_FFFF);
        close_out();
    end
endmodule : dma_socket_descriptor_regs_tb_top
